// ### hw/sfio_params.svh
// Purpose: offsets, field positions, resets and timing for sfio
// Assumes: 100 MHz aclk
// Notes:   byte addresses on AXI4-Lite
`ifndef SFIO_PARAMS_SVH
`define SFIO_PARAMS_SVH
`define SFIO_REG_CTRL     8'h00
`define SFIO_REG_STATUS   8'h04
`define SFIO_REG_MASK     8'h08
`define SFIO_REG_LIVE     8'h0c
`define SFIO_REG_WARN     8'h10
`define SFIO_REG_ZHIT     8'h14
`define SFIO_REG_ZRANGE   8'h18
`define SFIO_REG_NUMCFG   8'h1c
`define SFIO_CTRL_SERVO   0
`define SFIO_CTRL_AXIS    1
`define SFIO_ST_ESTOP     0
`define SFIO_ST_DOOR      1
`define SFIO_ST_MISMATCH  2
`define SFIO_ST_HAND      3
`define SFIO_ST_PNEU      4
`define SFIO_ST_W         5
`define SFIO_ZR_END_LSB   8
`define SFIO_ZONE_MAX     5'h08
`define SFIO_REG_RESET    32'h0000_0000
`define SFIO_CLK_HZ       100000000
`define SFIO_STOP_MS      100
`define SFIO_STOP_CYC     (`SFIO_STOP_MS * (`SFIO_CLK_HZ / 1000))
`define SFIO_NPINS        15
`endif

// ### hw/sfio_pkg.sv
// Purpose: shared types for sfio
// Assumes: nothing
// Notes:   pairs are normally closed, 1 = closed
package sfio_pkg;
	typedef struct packed {
		logic a;
		logic b;
	} sfio_pair_t;
	typedef struct packed {
		logic err_closed;
		logic estop_closed;
		logic mode_closed;
		logic axis_closed;
	} sfio_contacts_t;
	typedef enum logic [2:0] {
		SFIO_OFF  = 3'b001,
		SFIO_ON   = 3'b010,
		SFIO_STOP = 3'b100
	} sfio_state_t;
endpackage : sfio_pkg

// ### hw/sfio_safety_io.sv
// Purpose: robot safety and dedicated status i/o with AXI4-Lite regs
// Assumes: aclk 100 MHz, pins asynchronous to aclk
// Notes:   contacts: 1 = closed, 0 = open
// Notes on behaviour
// - level input function follows input level
// - edge input acts on rise, then holds
// - hand fault input raises echoed hand error
// - pneumatic fault input raises echoed error
// - per mechanism parts replacement warning output
// - up to 32 zone outputs, range max eight
// - numeric port config: four fields fixed order
// - dual closed estop, opening stops robot
// - dual closed door, opening forces servo off
// - dual mode selector picks manual or auto
// - error contact open while any error
// - estop contact opens on external or pendant
// - mode contact open manual, closed auto
// - axis sync output follows arm servo state
// - no power means all contacts open
// - hazard: stop first, then servo off
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "sfio_params.svh"
module sfio_safety_io
	import sfio_pkg::*;
#(
	parameter int unsigned STOP_SETTLE_CYC = `SFIO_STOP_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [31:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        hand_fault_request_m1,
	input  wire logic        hand_fault_request_m2,
	input  wire logic        hand_fault_request_m3,
	input  wire logic        pneumatic_fault_request_1,
	input  wire logic        pneumatic_fault_request_2,
	input  wire logic        pneumatic_fault_request_3,
	input  wire sfio_pair_t  estop_pair,
	input  wire sfio_pair_t  door_pair,
	input  wire sfio_pair_t  mode_pair,
	input  wire logic        pendant_estop_n,
	input  wire logic        servo_on_edge_in,
	input  wire logic        power_good,
	output logic [2:0]       hand_error_out,
	output logic [2:0]       pneumatic_error_out,
	output logic             parts_replace_warning_m1,
	output logic             parts_replace_warning_m2,
	output logic             parts_replace_warning_m3,
	output logic [31:0]      custom_zone_outputs,
	output logic [31:0]      num_port_cfg,
	output sfio_contacts_t   contacts,
	output logic             robot_stop,
	output logic             servo_enable,
	output logic             irq
);
	localparam int NP = `SFIO_NPINS;
	logic [NP-1:0]    pin_raw;
	logic [NP-1:0]    sync1;
	logic [NP-1:0]    sync2;
	logic [2:0]       hand_s;
	logic [2:0]       pneu_s;
	sfio_pair_t       estop_s;
	sfio_pair_t       door_s;
	sfio_pair_t       mode_s;
	logic             pend_ok;
	logic             son_s;
	logic             son_d;
	logic             pwr_ok;
	logic             estop_act;
	logic             door_open;
	logic             mismatch;
	logic             auto_mode;
	logic             hazard;
	logic             any_err;
	logic [`SFIO_ST_W-1:0] ev;
	logic [`SFIO_ST_W-1:0] lvl;
	logic [`SFIO_ST_W-1:0] lvl_d;
	logic [31:0]      ctrl;
	logic [31:0]      status;
	logic [31:0]      mask;
	logic [31:0]      warn;
	logic [31:0]      zhit;
	logic [31:0]      zrange;
	logic             aw_full;
	logic             w_full;
	logic [31:0]      aw_q;
	logic [31:0]      w_q;
	logic [3:0]       s_q;
	logic             do_wr;
	logic [7:0]       wr_addr;
	logic [31:0]      wr_data;
	logic [3:0]       wr_strb;
	logic             wr_ok;
	logic             servo_req;
	sfio_state_t      state;
	sfio_state_t      next_state;
	logic [31:0]      stop_cnt;
	logic [4:0]       z_lo;
	logic [4:0]       z_hi;
	logic             z_ok;

	// pin synchronisers
	assign pin_raw = {hand_fault_request_m3, hand_fault_request_m2,
		hand_fault_request_m1, pneumatic_fault_request_3,
		pneumatic_fault_request_2, pneumatic_fault_request_1,
		estop_pair, door_pair, mode_pair, pendant_estop_n,
		servo_on_edge_in, power_good};
	genvar gi;
	generate
		for (gi = 0; gi < NP; gi++) begin : g_sync
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					sync1[gi] <= 1'b0;
					sync2[gi] <= 1'b0;
				end else begin
					sync1[gi] <= pin_raw[gi];
					sync2[gi] <= sync1[gi];
				end
			end
		end
	endgenerate
	assign {hand_s, pneu_s, estop_s, door_s, mode_s, pend_ok, son_s,
		pwr_ok} = sync2;

	// redundant pair decode
	assign estop_act = !(estop_s.a && estop_s.b) || !pend_ok;
	assign door_open = !(door_s.a && door_s.b);
	assign auto_mode = mode_s.a && mode_s.b;
	assign mismatch  = (estop_s.a ^ estop_s.b) | (door_s.a ^ door_s.b)
		| (mode_s.a ^ mode_s.b);
	assign hazard    = estop_act || door_open;
	assign any_err   = mismatch || estop_act || (|hand_s) || (|pneu_s);

	// level and warning outputs follow their sources
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hand_error_out           <= 3'h0;
			pneumatic_error_out      <= 3'h0;
			parts_replace_warning_m1 <= 1'b0;
			parts_replace_warning_m2 <= 1'b0;
			parts_replace_warning_m3 <= 1'b0;
		end else begin
			hand_error_out           <= hand_s;
			pneumatic_error_out      <= pneu_s;
			parts_replace_warning_m1 <= warn[0];
			parts_replace_warning_m2 <= warn[1];
			parts_replace_warning_m3 <= warn[2];
		end
	end

	// zone outputs within a range of at most eight
	assign z_lo = zrange[4:0];
	assign z_hi = zrange[`SFIO_ZR_END_LSB +: 5];
	assign z_ok = (z_hi >= z_lo) && ((z_hi - z_lo) < `SFIO_ZONE_MAX);
	generate
		for (gi = 0; gi < 32; gi++) begin : g_zone
			always_ff @(posedge aclk) begin
				if (!aresetn)
					custom_zone_outputs[gi] <= 1'b0;
				else
					custom_zone_outputs[gi] <= z_ok && zhit[gi]
						&& (5'(gi) >= z_lo) && (5'(gi) <= z_hi);
			end
		end
	endgenerate

	// servo sequence: edge request, stop then servo off
	assign servo_req = (son_s && !son_d)
		|| (do_wr && wr_ok && wr_addr == `SFIO_REG_CTRL
		&& wr_strb[0] && wr_data[`SFIO_CTRL_SERVO]);

	always_comb begin
		next_state = state;
		unique case (state)
			SFIO_OFF: begin
				if (servo_req && !hazard && pwr_ok)
					next_state = SFIO_ON;
			end
			SFIO_ON: begin
				if (hazard || !pwr_ok)
					next_state = SFIO_STOP;
			end
			SFIO_STOP: begin
				if (stop_cnt >= STOP_SETTLE_CYC - 1)
					next_state = SFIO_OFF;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state        <= SFIO_OFF;
			stop_cnt     <= 32'h0;
			son_d        <= 1'b0;
			robot_stop   <= 1'b0;
			servo_enable <= 1'b0;
		end else begin
			state        <= next_state;
			stop_cnt     <= (state == SFIO_STOP)
				? stop_cnt + 32'h1 : 32'h0;
			son_d        <= son_s;
			robot_stop   <= (next_state == SFIO_STOP);
			servo_enable <= (next_state != SFIO_OFF);
		end
	end

	// output contacts, all open without power
	always_ff @(posedge aclk) begin
		if (!aresetn || !pwr_ok) begin
			contacts <= '0;
		end else begin
			contacts.err_closed   <= !any_err;
			contacts.estop_closed <= !estop_act;
			contacts.mode_closed  <= auto_mode;
			contacts.axis_closed  <= ctrl[`SFIO_CTRL_AXIS]
				&& (next_state != SFIO_OFF);
		end
	end

	// sticky events and interrupt
	assign lvl = {|pneu_s, |hand_s, mismatch, door_open, estop_act};
	assign ev  = lvl & ~lvl_d;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lvl_d  <= '0;
			status <= `SFIO_REG_RESET;
		end else begin
			lvl_d <= lvl;
			if (do_wr && wr_ok && wr_addr == `SFIO_REG_STATUS
				&& wr_strb[0])
				status[`SFIO_ST_W-1:0] <= (status[`SFIO_ST_W-1:0]
					& ~wr_data[`SFIO_ST_W-1:0]) | ev;
			else
				status[`SFIO_ST_W-1:0] <= status[`SFIO_ST_W-1:0] | ev;
		end
	end
	assign irq = |(status & mask);

	// axi4-lite write path
	assign awready = !aw_full && !bvalid;
	assign wready  = !w_full && !bvalid;
	assign do_wr   = (aw_full || (awvalid && awready))
		&& (w_full || (wvalid && wready)) && !bvalid;
	assign wr_addr = aw_full ? aw_q[7:0] : awaddr[7:0];
	assign wr_data = w_full ? w_q : wdata;
	assign wr_strb = w_full ? s_q : wstrb;
	assign wr_ok   = (aw_full ? aw_q[31:8] : awaddr[31:8]) == 24'h0
		&& (wr_addr[1:0] == 2'b00) && (wr_addr <= `SFIO_REG_NUMCFG);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full  <= 1'b0;
			aw_q    <= 32'h0;
			w_q     <= 32'h0;
			s_q     <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= 2'b00;
		end else begin
			if (do_wr) begin
				aw_full <= 1'b0;
				w_full  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= wr_ok ? 2'b00 : 2'b11;
			end else begin
				if (awvalid && awready) begin
					aw_full <= 1'b1;
					aw_q    <= awaddr;
				end
				if (wvalid && wready) begin
					w_full <= 1'b1;
					w_q    <= wdata;
					s_q    <= wstrb;
				end
				if (bvalid && bready)
					bvalid <= 1'b0;
			end
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (st[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction : merge

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl         <= `SFIO_REG_RESET;
			mask         <= `SFIO_REG_RESET;
			warn         <= `SFIO_REG_RESET;
			zhit         <= `SFIO_REG_RESET;
			zrange       <= `SFIO_REG_RESET;
			num_port_cfg <= `SFIO_REG_RESET;
		end else if (do_wr && wr_ok) begin
			unique case (wr_addr)
				`SFIO_REG_CTRL: ctrl <= merge(ctrl, wr_data, wr_strb)
					& 32'h0000_0002;
				`SFIO_REG_MASK: mask <= merge(mask, wr_data, wr_strb)
					& 32'h0000_001f;
				`SFIO_REG_WARN: warn <= merge(warn, wr_data, wr_strb)
					& 32'h0000_0007;
				`SFIO_REG_ZHIT: zhit <= merge(zhit, wr_data, wr_strb);
				`SFIO_REG_ZRANGE: zrange <= merge(zrange, wr_data,
					wr_strb) & 32'h0000_1f1f;
				`SFIO_REG_NUMCFG: num_port_cfg <= merge(num_port_cfg,
					wr_data, wr_strb);
				default: ;
			endcase
		end
	end

	// axi4-lite read path
	assign arready = !rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0;
			rresp  <= 2'b00;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp  <= 2'b00;
			unique case (araddr)
				32'(`SFIO_REG_CTRL):   rdata <= ctrl;
				32'(`SFIO_REG_STATUS): rdata <= status;
				32'(`SFIO_REG_MASK):   rdata <= mask;
				32'(`SFIO_REG_LIVE):   rdata <= {18'h0, state,
					pwr_ok, auto_mode, pneu_s, hand_s, door_open,
					estop_act, mismatch};
				32'(`SFIO_REG_WARN):   rdata <= warn;
				32'(`SFIO_REG_ZHIT):   rdata <= zhit;
				32'(`SFIO_REG_ZRANGE): rdata <= zrange;
				32'(`SFIO_REG_NUMCFG): rdata <= num_port_cfg;
				default: begin
					rdata <= 32'h0;
					rresp <= 2'b11;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	hand_echo_a: assert property (aresetn && $past(aresetn)
		|-> ##1 hand_error_out == $past(hand_s))
		else $error("hand error echo wrong");
	pneu_echo_a: assert property (##1 pneumatic_error_out
		== $past(pneu_s)) else $error("pneumatic echo wrong");
	err_open_a: assert property (any_err && pwr_ok
		|=> !contacts.err_closed) else $error("error contact closed");
	estop_open_a: assert property (estop_act
		|=> !contacts.estop_closed) else $error("estop contact closed");
	mode_contact_a: assert property (pwr_ok && $stable(pwr_ok)
		|=> contacts.mode_closed == $past(auto_mode))
		else $error("mode contact wrong");
	power_open_a: assert property (!pwr_ok
		|=> contacts == '0) else $error("contact closed without power");
	stop_first_a: assert property (state == SFIO_ON && hazard
		|=> state == SFIO_STOP ##1 robot_stop && servo_enable)
		else $error("servo cut before stop");
	edge_hold_a: assert property (state == SFIO_ON && !hazard
		&& pwr_ok |=> state == SFIO_ON) else $error("servo state lost");
	mismatch_a: assert property (mode_s.a != mode_s.b && pwr_ok
		|=> !contacts.err_closed) else $error("pair mismatch missed");
	axis_sync_a: assert property (pwr_ok && $stable(pwr_ok)
		|=> contacts.axis_closed == ($past(ctrl[`SFIO_CTRL_AXIS])
		&& servo_enable)) else $error("axis sync wrong");
	servo_cycle_c: cover property (state == SFIO_ON ##1 state == SFIO_STOP);
	door_event_c: cover property ($rose(door_open));
	irq_c: cover property ($rose(irq));
	zone_c: cover property (|custom_zone_outputs);
endmodule : sfio_safety_io
`default_nettype wire

// ### tb/sfio_switch_model.sv
// Purpose: external safety switches facing the safety i/o block
// Assumes: contacts are normally closed, 1 = closed
// Notes:   split_sel inverts one mode channel only, a wiring fault
`timescale 1ns/1ns
`default_nettype none
module sfio_switch_model
	import sfio_pkg::*;
(
	input  wire logic  press_estop,
	input  wire logic  open_door,
	input  wire logic  auto_sel,
	input  wire logic  split_sel,
	output sfio_pair_t estop_pair,
	output sfio_pair_t door_pair,
	output sfio_pair_t mode_pair
);
	// both channels open together when pressed
	assign estop_pair = {!press_estop, !press_estop};
	assign door_pair  = {!open_door, !open_door};
	// channels disagree only when a fault is commanded
	assign mode_pair  = {auto_sel, auto_sel ^ split_sel};
	// no stop or servo-off command is ever sent with an event
endmodule : sfio_switch_model
`default_nettype wire

// ### tb/sfio_safety_io_tb.sv
// Purpose: self-checking bench for the safety i/o block
// Assumes: 100 MHz aclk, short stop phase parameter
// Notes:   bready and rready held high throughout
`timescale 1ns/1ns
`default_nettype none
`include "sfio_params.svh"
module sfio_safety_io_tb
	import sfio_pkg::*;
;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
	logic bready = 1, rready = 1, pend_n = 1, srv_pin = 0, power_good = 1;
	logic press = 0, door = 0, auto_sel = 0, split = 0;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, zone, ncfg, rd;
	logic [3:0] wstrb = 4'hf;
	logic [2:0] hf = 0, pf = 0, hand_o, pneu_o, warn;
	logic [1:0] bresp, rresp, rsp;
	logic awready, wready, bvalid, arready, rvalid, irq, rstop, srv_en;
	sfio_pair_t ep, dp, mp;
	sfio_contacts_t ct;
	int n_fail = 0, num_checks = 0;
	always #5 aclk = ~aclk;
	sfio_switch_model i_sw (.press_estop(press), .open_door(door),
		.auto_sel(auto_sel), .split_sel(split), .estop_pair(ep),
		.door_pair(dp), .mode_pair(mp));
	sfio_safety_io #(.STOP_SETTLE_CYC(16)) i_dut (.aclk, .aresetn, .awaddr,
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .hand_fault_request_m1(hf[0]),
		.hand_fault_request_m2(hf[1]), .hand_fault_request_m3(hf[2]),
		.pneumatic_fault_request_1(pf[0]), .pneumatic_fault_request_2(pf[1]),
		.pneumatic_fault_request_3(pf[2]), .estop_pair(ep), .door_pair(dp),
		.mode_pair(mp), .pendant_estop_n(pend_n), .servo_on_edge_in(srv_pin),
		.power_good, .hand_error_out(hand_o), .pneumatic_error_out(pneu_o),
		.parts_replace_warning_m1(warn[0]), .parts_replace_warning_m2(warn[1]),
		.parts_replace_warning_m3(warn[2]), .custom_zone_outputs(zone),
		.num_port_cfg(ncfg), .contacts(ct), .robot_stop(rstop),
		.servo_enable(srv_en), .irq);
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge aclk);
	endtask : step
	// both halves offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit aw, w;
		aw = 0;
		w = 0;
		awaddr <= {24'h0, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && awready === 1'b1) begin
				aw = 1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1) begin
				w = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		rsp = bresp;
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rd = rdata;
		rsp = rresp;
	endtask : rdr
	initial begin
		#100000;
		n_fail++;
		complete_run();
	end
	initial begin
		step(2);
		aresetn <= 1'b1;
		step(6);
		rdr(`SFIO_REG_MASK);
		chk(rd, `SFIO_REG_RESET);
		rdr(8'h20);
		chk(32'(rsp), 32'h3);
		wr(8'h22, 32'h1);
		chk(32'(rsp), 32'h3);
		$display("test registers done");
		// each fault input alone, echoed and released
		for (int i = 0; i < 6; i++) begin
			if (i < 3)
				hf <= 3'(1 << i);
			else
				pf <= 3'(1 << (i - 3));
			step(5);
			chk(32'({pneu_o, hand_o}), 32'(1 << i));
			chk(32'(ct.err_closed), 32'h0);
			hf <= 3'h0;
			pf <= 3'h0;
			step(5);
			chk(32'({pneu_o, hand_o}), 32'h0);
		end
		$display("test faults done");
		wr(`SFIO_REG_STATUS, 32'h1f);
		wr(`SFIO_REG_MASK, 32'h8);
		pf <= 3'h2;
		step(5);
		chk(32'(irq), 32'h0);
		hf <= 3'h4;
		step(5);
		hf <= 3'h0;
		pf <= 3'h0;
		step(5);
		chk(32'(irq), 32'h1);
		wr(`SFIO_REG_STATUS, 32'h8);
		step(1);
		chk(32'(irq), 32'h0);
		$display("test interrupt done");
		wr(`SFIO_REG_WARN, 32'h5);
		step(1);
		chk(32'(warn), 32'h5);
		wr(`SFIO_REG_NUMCFG, 32'h44332211);
		chk(ncfg, 32'h44332211);
		wr(`SFIO_REG_ZHIT, 32'hffffffff);
		wr(`SFIO_REG_ZRANGE, 32'h0b04);
		step(1);
		chk(zone, 32'h00000ff0);
		wr(`SFIO_REG_ZRANGE, 32'h0c04);
		step(1);
		chk(zone, 32'h0);
		wr(`SFIO_REG_ZRANGE, 32'h1f18);
		step(1);
		chk(zone, 32'hff000000);
		$display("test outputs done");
		auto_sel <= 1'b1;
		step(5);
		chk(32'(ct.mode_closed), 32'h1);
		split <= 1'b1;
		step(5);
		chk(32'(ct.mode_closed), 32'h0);
		chk(32'(ct.err_closed), 32'h0);
		rdr(`SFIO_REG_LIVE);
		chk(32'(rd[0]), 32'h1);
		split <= 1'b0;
		auto_sel <= 1'b0;
		step(5);
		chk(32'({ct.err_closed, ct.mode_closed}), 32'h2);
		$display("test mode done");
		wr(`SFIO_REG_CTRL, 32'h2);
		srv_pin <= 1'b1;
		step(5);
		chk(32'({srv_en, ct.axis_closed}), 32'h3);
		srv_pin <= 1'b0;
		step(5);
		chk(32'(srv_en), 32'h1);
		press <= 1'b1;
		step(5);
		chk(32'({rstop, srv_en, ct.estop_closed}), 32'h6);
		step(24);
		chk(32'({rstop, srv_en, ct.axis_closed}), 32'h0);
		press <= 1'b0;
		step(5);
		wr(`SFIO_REG_CTRL, 32'h1);
		step(3);
		chk(32'(srv_en), 32'h1);
		door <= 1'b1;
		step(5);
		chk(32'({rstop, srv_en}), 32'h3);
		step(24);
		chk(32'({rstop, srv_en}), 32'h0);
		door <= 1'b0;
		$display("test servo done");
		pend_n <= 1'b0;
		step(5);
		chk(32'(ct.estop_closed), 32'h0);
		pend_n <= 1'b1;
		step(5);
		chk(32'(ct.estop_closed), 32'h1);
		auto_sel <= 1'b1;
		power_good <= 1'b0;
		step(5);
		chk(32'(ct), 32'h0);
		power_good <= 1'b1;
		$display("test contacts done");
		complete_run();
	end
endmodule : sfio_safety_io_tb
`default_nettype wire
